//--- hw/nvsc_pkg.sv
// Shared constants and types for the nonvolatile SRAM host controller.
package nvsc_pkg;

  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CNT_W = 24;
  localparam int IDX_W = 3;

  // ----------------------------------------------------------------
  // Times and derived cycle counts (least times round up)
  // ----------------------------------------------------------------
  localparam int ADDRESS_ACCESS_TIME_NS = 35;
  localparam int ADDRESS_ACCESS_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_WINDOW_NS = 35;
  localparam int DATA_SETUP_CYC = (DATA_SETUP_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_REQUEST_DELAY_NS = 25_000;
  localparam int STORE_REQUEST_DELAY_CYC =
    (STORE_REQUEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_DURATION_NS = 15_000_000;
  localparam int STORE_DURATION_CYC = (STORE_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECALL_DURATION_NS = 200_000;
  localparam int RECALL_DURATION_CYC = (RECALL_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_RECALL_DURATION_NS = 20_000_000;
  localparam int POWERUP_RECALL_DURATION_CYC =
    (POWERUP_RECALL_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POST_STORE_HOLDOFF_NS = 20_000;
  localparam int POST_STORE_HOLDOFF_CYC =
    (POST_STORE_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_SETTLE_CYC = 4;

  // ----------------------------------------------------------------
  // Software sequence addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SEQ_ADDR_1 = 17'h0_4e38;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_2 = 17'h0_b1c7;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_3 = 17'h0_83e0;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_4 = 17'h0_7c1f;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_5 = 17'h0_703f;
  localparam logic [ADDR_W-1:0] SEQ_STORE_ADDR = 17'h0_0fc0;
  localparam logic [ADDR_W-1:0] SEQ_RECALL_ADDR = 17'h0_0c63;
  localparam logic [ADDR_W-1:0] SEQ_AS_OFF_ADDR = 17'h0_0b45;
  localparam logic [ADDR_W-1:0] SEQ_AS_ON_ADDR = 17'h0_0b46;
  localparam logic [IDX_W-1:0] SEQ_LAST_IDX = 3'h5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic AUTOSTORE_RESET = 1'b1;
  localparam logic STRAP_HIGH_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NVSC_OP_READ = 3'h0,
    NVSC_OP_WRITE = 3'h1,
    NVSC_OP_STORE = 3'h2,
    NVSC_OP_RECALL = 3'h3,
    NVSC_OP_AS_OFF = 3'h4,
    NVSC_OP_AS_ON = 3'h5,
    NVSC_OP_HW_STORE = 3'h6
  } nvsc_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_RELEASE = 3'h2,
    ST_NVWAIT = 3'h6,
    ST_HOLDOFF = 3'h7,
    ST_HWREQ = 3'h5,
    ST_INIT = 3'h4
  } nvsc_state_t;

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [IDX_W-1:0] idx,
                                                  input nvsc_op_t op);
    logic [ADDR_W-1:0] a;
    a = SEQ_ADDR_1;
    case (idx)
      3'h0: a = SEQ_ADDR_1;
      3'h1: a = SEQ_ADDR_2;
      3'h2: a = SEQ_ADDR_3;
      3'h3: a = SEQ_ADDR_4;
      3'h4: a = SEQ_ADDR_5;
      default:
      begin
        case (op)
          NVSC_OP_STORE: a = SEQ_STORE_ADDR;
          NVSC_OP_RECALL: a = SEQ_RECALL_ADDR;
          NVSC_OP_AS_OFF: a = SEQ_AS_OFF_ADDR;
          default: a = SEQ_AS_ON_ADDR;
        endcase
      end
    endcase
    return a;
  endfunction

endpackage

//--- hw/nvsc_sync3.sv
// Three-stage synchroniser that accepts a change once the last two stages agree.
module nvsc_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic d,
  output logic q
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      q_r <= RESET_VAL;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
      begin
        q_r <= s3_r;
      end
    end
  end

  assign q = q_r;

endmodule

//--- hw/nvsc_host.sv
// Host controller that drives the nonvolatile SRAM through its pins.
// ----------------------------------------------------------------
// Overview of operation
// - Host holds address stable, output enable high during writes.
// - No capacitor: host disables power-loss store.
// - Accesses refused until busy returns high.
// - Six fixed reads start software store.
// - Six fixed reads start software recall.
// - Sequence ending 0x0B45 disables power-loss store.
// - Sequence ending 0x0B46 re-enables it.
// ----------------------------------------------------------------
module nvsc_host #(
  parameter bit CAP_FITTED = 1'b1,
  parameter int unsigned REQ_CYC = nvsc_pkg::STORE_REQUEST_DELAY_CYC,
  parameter int unsigned STORE_CYC = nvsc_pkg::STORE_DURATION_CYC,
  parameter int unsigned RECALL_CYC = nvsc_pkg::RECALL_DURATION_CYC,
  parameter int unsigned POWERUP_CYC = nvsc_pkg::POWERUP_RECALL_DURATION_CYC,
  parameter int unsigned HOLDOFF_CYC = nvsc_pkg::POST_STORE_HOLDOFF_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire nvsc_pkg::nvsc_op_t cmd_op,
  input wire logic [16:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic mem_busy,
  output logic autostore_on,
  output logic [16:0] address_pins,
  output logic [7:0] data_pins_o,
  output logic data_pins_oe_n,
  input wire logic [7:0] data_pins_i,
  output logic chip_en_n,
  output logic write_en_n,
  output logic out_en_n,
  input wire logic store_busy_n_i,
  output logic store_busy_n_o,
  output logic store_busy_n_oe_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int CW = nvsc_pkg::CNT_W;
  localparam logic [CW-1:0] RD_CW = CW'(nvsc_pkg::ADDRESS_ACCESS_CYC - 1);
  localparam logic [CW-1:0] WR_CW = CW'(nvsc_pkg::DATA_SETUP_CYC - 1);
  localparam logic [CW-1:0] REQ_CW = CW'(REQ_CYC);
  localparam logic [CW-1:0] STORE_CW = CW'(STORE_CYC);
  localparam logic [CW-1:0] RECALL_CW = CW'(RECALL_CYC);
  localparam logic [CW-1:0] POWERUP_CW = CW'(POWERUP_CYC);
  localparam logic [CW-1:0] HOLDOFF_CW = CW'(HOLDOFF_CYC);
  localparam logic [CW-1:0] SETTLE_CW = CW'(nvsc_pkg::BUSY_SETTLE_CYC);

  typedef struct packed {
    nvsc_pkg::nvsc_state_t st;
    nvsc_pkg::nvsc_op_t op;
    logic [CW-1:0] cnt;
    logic [2:0] idx;
    logic [16:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rsp;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe_n;
    logic hsb_oe_n;
    logic auto_en;
  } nvsc_regs_t;

  nvsc_regs_t r;
  nvsc_regs_t n;
  logic busy_q;
  logic seq_op;
  logic auto_fix;

  nvsc_sync3 #(
    .RESET_VAL(nvsc_pkg::STRAP_HIGH_RESET)
  ) u_busy_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d(store_busy_n_i),
    .q(busy_q)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Without a backup capacitor an automatic store would corrupt the shadow copy, so the
  // controller disables it before taking any user command.
  assign auto_fix = !CAP_FITTED && r.auto_en;
  assign seq_op = (r.op != nvsc_pkg::NVSC_OP_READ) && (r.op != nvsc_pkg::NVSC_OP_WRITE);
  assign cmd_ready = (r.st == nvsc_pkg::ST_IDLE) && busy_q && !auto_fix;

  always_comb
  begin
    n = r;
    n.rsp = 1'b0;
    case (r.st)
      nvsc_pkg::ST_INIT:
      begin
        if (r.cnt != '0)
        begin
          n.cnt = r.cnt - 1'b1;
        end
        else if (busy_q)
        begin
          n.st = nvsc_pkg::ST_HOLDOFF;
          n.cnt = HOLDOFF_CW;
        end
      end
      nvsc_pkg::ST_IDLE:
      begin
        if (!busy_q)
        begin
          n.st = nvsc_pkg::ST_NVWAIT;
          n.cnt = '0;
        end
        else if (auto_fix)
        begin
          n.op = nvsc_pkg::NVSC_OP_AS_OFF;
          n.idx = '0;
          n.addr = nvsc_pkg::seq_addr(3'h0, nvsc_pkg::NVSC_OP_AS_OFF);
          n.st = nvsc_pkg::ST_SETUP;
        end
        else if (cmd_valid)
        begin
          n.op = cmd_op;
          n.wdata = cmd_wdata;
          n.idx = '0;
          if (cmd_op == nvsc_pkg::NVSC_OP_HW_STORE)
          begin
            n.st = nvsc_pkg::ST_HWREQ;
            n.cnt = REQ_CW;
            n.hsb_oe_n = 1'b0;
          end
          else
          begin
            n.st = nvsc_pkg::ST_SETUP;
            if ((cmd_op == nvsc_pkg::NVSC_OP_READ) || (cmd_op == nvsc_pkg::NVSC_OP_WRITE))
            begin
              n.addr = cmd_addr;
            end
            else
            begin
              n.addr = nvsc_pkg::seq_addr(3'h0, cmd_op);
            end
          end
        end
      end
      nvsc_pkg::ST_SETUP:
      begin
        n.st = nvsc_pkg::ST_STROBE;
        n.ce_n = 1'b0;
        if (r.op == nvsc_pkg::NVSC_OP_WRITE)
        begin
          n.we_n = 1'b0;
          n.dq_oe_n = 1'b0;
          n.cnt = WR_CW;
        end
        else
        begin
          n.oe_n = 1'b0;
          n.cnt = RD_CW;
        end
      end
      nvsc_pkg::ST_STROBE:
      begin
        if (r.cnt != '0)
        begin
          n.cnt = r.cnt - 1'b1;
        end
        else
        begin
          n.st = nvsc_pkg::ST_RELEASE;
          n.ce_n = 1'b1;
          n.we_n = 1'b1;
          n.oe_n = 1'b1;
          if (r.op != nvsc_pkg::NVSC_OP_WRITE)
          begin
            n.rdata = data_pins_i;
          end
        end
      end
      nvsc_pkg::ST_RELEASE:
      begin
        n.dq_oe_n = 1'b1;
        if (r.op == nvsc_pkg::NVSC_OP_READ)
        begin
          n.rsp = 1'b1;
          n.st = nvsc_pkg::ST_IDLE;
        end
        else if (r.op == nvsc_pkg::NVSC_OP_WRITE)
        begin
          n.st = nvsc_pkg::ST_IDLE;
        end
        else if (r.idx != nvsc_pkg::SEQ_LAST_IDX)
        begin
          n.idx = 3'(r.idx + 3'h1);
          n.addr = nvsc_pkg::seq_addr(3'(r.idx + 3'h1), r.op);
          n.st = nvsc_pkg::ST_SETUP;
        end
        else
        begin
          case (r.op)
            nvsc_pkg::NVSC_OP_STORE:
            begin
              n.st = nvsc_pkg::ST_NVWAIT;
              n.cnt = STORE_CW;
            end
            nvsc_pkg::NVSC_OP_RECALL:
            begin
              n.st = nvsc_pkg::ST_NVWAIT;
              n.cnt = RECALL_CW;
            end
            nvsc_pkg::NVSC_OP_AS_OFF:
            begin
              n.auto_en = 1'b0;
              n.st = nvsc_pkg::ST_IDLE;
            end
            default:
            begin
              n.auto_en = 1'b1;
              n.st = nvsc_pkg::ST_IDLE;
            end
          endcase
        end
      end
      nvsc_pkg::ST_HWREQ:
      begin
        if (r.cnt != '0)
        begin
          n.cnt = r.cnt - 1'b1;
        end
        else
        begin
          n.hsb_oe_n = 1'b1;
          n.st = nvsc_pkg::ST_NVWAIT;
          n.cnt = SETTLE_CW;
        end
      end
      nvsc_pkg::ST_NVWAIT:
      begin
        if (r.cnt != '0)
        begin
          n.cnt = r.cnt - 1'b1;
        end
        else if (busy_q)
        begin
          n.st = nvsc_pkg::ST_HOLDOFF;
          n.cnt = HOLDOFF_CW;
        end
      end
      nvsc_pkg::ST_HOLDOFF:
      begin
        if (!busy_q)
        begin
          n.st = nvsc_pkg::ST_NVWAIT;
          n.cnt = '0;
        end
        else if (r.cnt != '0)
        begin
          n.cnt = r.cnt - 1'b1;
        end
        else
        begin
          n.st = nvsc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        n.st = nvsc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.st <= nvsc_pkg::ST_INIT;
      r.cnt <= POWERUP_CW;
      r.ce_n <= 1'b1;
      r.we_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.dq_oe_n <= 1'b1;
      r.hsb_oe_n <= 1'b1;
      r.auto_en <= nvsc_pkg::AUTOSTORE_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_valid = r.rsp;
  assign rsp_data = r.rdata;
  assign mem_busy = (r.st != nvsc_pkg::ST_IDLE);
  assign autostore_on = r.auto_en;
  assign address_pins = r.addr;
  assign data_pins_o = r.wdata;
  assign data_pins_oe_n = r.dq_oe_n;
  assign chip_en_n = r.ce_n;
  assign write_en_n = r.we_n;
  assign out_en_n = r.oe_n;
  assign store_busy_n_o = 1'b0;
  assign store_busy_n_oe_n = r.hsb_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_strobe_open;
    $fell(r.ce_n);
  endsequence

  sequence s_seq_done;
    (r.st == nvsc_pkg::ST_RELEASE) && (r.idx == nvsc_pkg::SEQ_LAST_IDX);
  endsequence

  no_access_busy_a: assert property (s_strobe_open |-> $past(busy_q, 2))
    else $error("Access started while busy was low.");
  write_oe_high_a: assert property (!r.we_n |-> (r.oe_n && !r.dq_oe_n))
    else $error("Output enable low during write.");
  addr_stable_a: assert property (!r.ce_n |=> $stable(r.addr))
    else $error("Address moved during an access.");
  seq_we_high_a: assert property ((seq_op && (r.st != nvsc_pkg::ST_IDLE)) |-> r.we_n)
    else $error("Write strobe low inside a software sequence.");
  store_wait_a: assert property ((s_seq_done and (r.op == nvsc_pkg::NVSC_OP_STORE))
      |=> (r.st == nvsc_pkg::ST_NVWAIT) && (r.cnt == STORE_CW))
    else $error("Software store wait not started.");
  as_off_a: assert property ((s_seq_done and (r.op == nvsc_pkg::NVSC_OP_AS_OFF))
      |=> !autostore_on)
    else $error("Power-loss store flag not cleared.");
  holdoff_a: assert property (((r.st == nvsc_pkg::ST_NVWAIT) && (r.cnt == '0) && busy_q)
      |=> (r.st == nvsc_pkg::ST_HOLDOFF) && (r.cnt == HOLDOFF_CW) ##1 r.ce_n)
    else $error("Holdoff after busy release missing.");
  hw_req_a: assert property ($fell(r.hsb_oe_n) |-> (r.st == nvsc_pkg::ST_HWREQ)
      && (r.cnt == REQ_CW))
    else $error("Store request pulse malformed.");
  init_block_a: assert property ((r.st == nvsc_pkg::ST_INIT) |-> !cmd_ready)
    else $error("Command taken during power-up recall.");

endmodule

//--- test/nvsc_dev_model.sv
// Behavioural model of the nonvolatile SRAM device seen from its pins.
module nvsc_dev_model #(
  parameter int REQ_T = 15,
  parameter int ST_T = 300,
  parameter int RC_T = 30,
  parameter int PU_T = 150
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [16:0] address_pins,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  input wire logic chip_en_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic busy_wire,
  output logic dev_pull,
  output logic [7:0] store_cnt,
  output logic asave
);
  timeunit 1ns;
  timeprecision 1ps;
  bit [7:0] mem [0:131071];
  bit [7:0] nv [0:131071];
  logic [16:0] ra, wa;
  logic [7:0] wd, last_q;
  logic rp, wp, latch, in_rst, rd_on, act;
  int cnt, req, seq;
  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  function automatic logic [13:0] pre(input int i);
    case (i)
      0: return 14'h0e38;
      1: return 14'h31c7;
      2: return 14'h03e0;
      3: return 14'h3c1f;
      default: return 14'h303f;
    endcase
  endfunction
  initial
  begin
    store_cnt = 8'h00;
    last_q = 8'h00;
    asave = 1'b1;
    latch = 1'b0;
    in_rst = 1'b0;
    cnt = 0;
  end
  assign rd_on = !chip_en_n && !out_en_n && write_en_n && busy_wire && cnt == 0;
  assign act = !chip_en_n && !write_en_n && busy_wire && cnt == 0;
  // A released bus shows a changing pattern so stale data never passes as a read.
  assign dq_o = rd_on ? mem[address_pins] : ~last_q;
  always @(posedge mclk)
    last_q <= dq_o;
  // ----------------------------------------------------------------
  // Array, sequences and nonvolatile operations
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      if (!in_rst && asave && latch)
        nv <= mem;
      in_rst <= 1'b1;
      cnt <= PU_T;
      dev_pull <= 1'b1;
      seq <= 0;
      rp <= 1'b0;
      wp <= 1'b0;
      req <= 0;
    end
    else
    begin
      if (in_rst)
      begin
        mem <= nv;
        latch <= 1'b0;
        in_rst <= 1'b0;
      end
      rp <= rd_on;
      ra <= address_pins;
      wp <= act;
      wa <= address_pins;
      wd <= dq_i;
      if (wp && !act)
      begin
        mem[wa] <= wd;
        latch <= 1'b1;
        seq <= 0;
      end
      if (cnt != 0)
      begin
        cnt <= cnt - 1;
        // The strong drive-high pulse is shown as a plain release to the pull-up.
        if (cnt == 1)
          dev_pull <= 1'b0;
      end
      else if (rp && !rd_on)
      begin
        if (seq == 5)
        begin
          seq <= 0;
          case (ra[13:0])
            14'h0fc0:
            begin
              nv <= mem;
              latch <= 1'b0;
              cnt <= ST_T;
              dev_pull <= 1'b1;
              store_cnt <= store_cnt + 8'h01;
            end
            14'h0c63:
            begin
              mem <= nv;
              latch <= 1'b0;
              cnt <= RC_T;
            end
            14'h0b45: asave <= 1'b0;
            14'h0b46: asave <= 1'b1;
            default: seq <= 0;
          endcase
        end
        else if (ra[13:0] == pre(seq))
          seq <= seq + 1;
        else
          seq <= (ra[13:0] == pre(0)) ? 1 : 0;
      end
      else if (!busy_wire && !dev_pull)
      begin
        req <= req + 1;
        if (req == REQ_T && latch)
        begin
          nv <= mem;
          latch <= 1'b0;
          cnt <= ST_T;
          dev_pull <= 1'b1;
          store_cnt <= store_cnt + 8'h01;
        end
      end
      else
        req <= 0;
    end
  end
endmodule

//--- test/testbench.sv
// Self-checking testbench for the nonvolatile SRAM host controller.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 10;
  localparam int DST = 300;
  logic mclk, sys_rst, cmd_valid, ext_pull, cmd_ready, rsp_valid, mem_busy, autostore_on;
  logic data_pins_oe_n, chip_en_n, write_en_n, out_en_n, busy_o, busy_oe_n;
  logic dev_pull, busy_wire, asave;
  nvsc_pkg::nvsc_op_t cmd_op;
  logic [16:0] cmd_addr, address_pins;
  logic [16:0] ad [0:9];
  logic [7:0] cmd_wdata, rsp_data, data_pins_o, dq_o, bus, store_cnt, rd, d;
  int failures = 0;
  int comparisons = 0;
  int cyc;
  bit [7:0] sram_e [0:131071];
  bit [7:0] nv_e [0:131071];
  logic [16:0] ap2;
  logic [7:0] do2, dq2, bus2, sc2;
  logic rdy2, as2, ce2, we2, oe2, dqoe2, bo2, boe2, pull2, bw2, asave2;
  // ----------------------------------------------------------------
  // Wiring
  // ----------------------------------------------------------------
  assign bus = !data_pins_oe_n ? data_pins_o : dq_o;
  assign busy_wire = !((!busy_oe_n && !busy_o) || dev_pull || ext_pull);
  nvsc_host #(.REQ_CYC(20), .STORE_CYC(200), .RECALL_CYC(50), .POWERUP_CYC(100),
    .HOLDOFF_CYC(HOLD)) u_nvsc_host (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_busy(mem_busy),
    .autostore_on(autostore_on), .address_pins(address_pins), .data_pins_o(data_pins_o),
    .data_pins_oe_n(data_pins_oe_n), .data_pins_i(bus), .chip_en_n(chip_en_n),
    .write_en_n(write_en_n), .out_en_n(out_en_n), .store_busy_n_i(busy_wire),
    .store_busy_n_o(busy_o), .store_busy_n_oe_n(busy_oe_n));
  nvsc_dev_model #(.ST_T(DST)) u_nvsc_dev_model (.mclk(mclk), .sys_rst(sys_rst),
    .address_pins(address_pins), .dq_i(bus), .dq_o(dq_o), .chip_en_n(chip_en_n),
    .write_en_n(write_en_n), .out_en_n(out_en_n), .busy_wire(busy_wire),
    .dev_pull(dev_pull), .store_cnt(store_cnt), .asave(asave));
  // Second pair without a backup capacitor: its controller must switch the power-loss store off.
  assign bus2 = !dqoe2 ? do2 : dq2;
  assign bw2 = !((!boe2 && !bo2) || pull2);
  nvsc_host #(.CAP_FITTED(1'b0), .REQ_CYC(20), .STORE_CYC(200), .RECALL_CYC(50),
    .POWERUP_CYC(100), .HOLDOFF_CYC(HOLD)) u_nvsc_host_nocap (.mclk(mclk), .sys_rst(sys_rst),
    .cmd_valid(1'b0), .cmd_ready(rdy2), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(), .rsp_data(), .mem_busy(), .autostore_on(as2),
    .address_pins(ap2), .data_pins_o(do2), .data_pins_oe_n(dqoe2), .data_pins_i(bus2),
    .chip_en_n(ce2), .write_en_n(we2), .out_en_n(oe2), .store_busy_n_i(bw2),
    .store_busy_n_o(bo2), .store_busy_n_oe_n(boe2));
  nvsc_dev_model #(.ST_T(DST)) u_nvsc_dev_model_nocap (.mclk(mclk), .sys_rst(sys_rst),
    .address_pins(ap2), .dq_i(bus2), .dq_o(dq2), .chip_en_n(ce2), .write_en_n(we2),
    .out_en_n(oe2), .busy_wire(bw2), .dev_pull(pull2), .store_cnt(sc2), .asave(asave2));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [7:0] exp_rd(input logic [16:0] a);
    return sram_e[a];
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_cmd(input nvsc_pkg::nvsc_op_t op, input logic [16:0] a, input logic [7:0] wd);
    int n;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 3000);
    cmd_valid <= 1'b0;
    rd = 8'hxx;
    cyc = 0;
    do
    begin
      @(posedge mclk);
      cyc++;
      if (rsp_valid === 1'b1)
        rd = rsp_data;
    end while (cmd_ready !== 1'b1 && cyc < 3000);
    if (n >= 3000 || cyc >= 3000)
      check("cmd_done", 8'h01, 8'h00);
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    cyc = 0;
    do
    begin
      @(posedge mclk);
      cyc++;
    end while (cmd_ready !== 1'b1 && cyc < 3000);
  endtask
  task automatic finish_test();
    $display("counts: comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge mclk);
    failures++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = nvsc_pkg::NVSC_OP_READ;
    cmd_addr = 17'h0_0000;
    cmd_wdata = 8'h00;
    ext_pull = 1'b0;
    void'($urandom(97316));
    do_reset();
    check("autostore_on", 8'h01, {7'h00, autostore_on});
    $display("test init done");
    ad[0] = 17'h0_0000;
    ad[1] = 17'h1_ffff;
    for (int i = 2; i < 10; i++)
      ad[i] = 17'($urandom);
    for (int i = 0; i < 10; i++)
    begin
      d = 8'($urandom);
      do_cmd(nvsc_pkg::NVSC_OP_WRITE, ad[i], d);
      sram_e[ad[i]] = d;
    end
    for (int i = 9; i >= 0; i--)
    begin
      do_cmd(nvsc_pkg::NVSC_OP_READ, ad[i], 8'h00);
      check("read_data", exp_rd(ad[i]), rd);
    end
    $display("test rw done");
    check("nocap_ready", 8'h01, {7'h00, rdy2});
    check("nocap_as_off", 8'h00, {7'h00, as2});
    check("nocap_dev_as_off", 8'h00, {7'h00, asave2});
    check("nocap_no_store", 8'h00, sc2);
    do_cmd(nvsc_pkg::NVSC_OP_STORE, 17'h0_0000, 8'h00);
    check("store_cnt", 8'h01, store_cnt);
    check("store_wait", 8'h01, {7'h00, cyc > DST + HOLD});
    nv_e = sram_e;
    $display("test sw_store done");
    do_cmd(nvsc_pkg::NVSC_OP_WRITE, ad[2], ~sram_e[ad[2]]);
    do_cmd(nvsc_pkg::NVSC_OP_RECALL, 17'h0_0000, 8'h00);
    sram_e = nv_e;
    do_cmd(nvsc_pkg::NVSC_OP_READ, ad[2], 8'h00);
    check("recall_data", exp_rd(ad[2]), rd);
    $display("test recall done");
    do_cmd(nvsc_pkg::NVSC_OP_HW_STORE, 17'h0_0000, 8'h00);
    check("hw_store_skip", 8'h01, store_cnt);
    d = 8'($urandom);
    do_cmd(nvsc_pkg::NVSC_OP_WRITE, ad[3], d);
    sram_e[ad[3]] = d;
    do_cmd(nvsc_pkg::NVSC_OP_HW_STORE, 17'h0_0000, 8'h00);
    check("hw_store_cnt", 8'h02, store_cnt);
    check("hw_store_wait", 8'h01, {7'h00, cyc > DST + HOLD});
    $display("test hw_store done");
    ext_pull <= 1'b1;
    repeat (30) @(posedge mclk);
    check("ready_ext_busy", 8'h00, {7'h00, cmd_ready});
    check("mem_busy", 8'h01, {7'h00, mem_busy});
    ext_pull <= 1'b0;
    cyc = 0;
    do
    begin
      @(posedge mclk);
      cyc++;
    end while (cmd_ready !== 1'b1 && cyc < 3000);
    check("ext_holdoff", 8'h01, {7'h00, cyc > HOLD && cyc < 3000});
    check("mem_idle", 8'h00, {7'h00, mem_busy});
    check("ext_no_store", 8'h02, store_cnt);
    $display("test ext_busy done");
    do_cmd(nvsc_pkg::NVSC_OP_AS_OFF, 17'h0_0000, 8'h00);
    check("as_off", 8'h00, {7'h00, autostore_on});
    check("dev_as_off", 8'h00, {7'h00, asave});
    do_cmd(nvsc_pkg::NVSC_OP_AS_ON, 17'h0_0000, 8'h00);
    check("as_on", 8'h01, {7'h00, autostore_on});
    check("dev_as_on", 8'h01, {7'h00, asave});
    $display("test autostore done");
    d = sram_e[ad[4]] ^ 8'($urandom_range(255, 1));
    do_cmd(nvsc_pkg::NVSC_OP_WRITE, ad[4], d);
    sram_e[ad[4]] = d;
    do_reset();
    do_cmd(nvsc_pkg::NVSC_OP_READ, ad[4], 8'h00);
    check("power_cycle", exp_rd(ad[4]), rd);
    $display("test power_cycle done");
    finish_test();
  end
endmodule
